// ===== design/brbio_register_bank.v
// Purpose: Register bank of the bridge with its six-pin programmable I/O port
// Assumes: Single clock clk_sys at 100 MHz, AXI4-Lite master, pins sampled async
// Notes:   Bus engine registers are plain storage, own address with bit 0 cleared; status reads its reset value

`include "brbio_defines.vh"

// How it works
// - The host link is a mode 3 serial slave at up to 1.2 Mbit/s, here reached as bus accesses.
// - Each programmable pin has its own two-bit type field in the config register.
// - Pin n takes its type from config bits 2n+1..2n: 00 quasi, 01 input, 10 push-pull, 11 open-drain.
// - The two fixed pins are always quasi-bidirectional and have no type field.
// - A quasi pin turns on its very weak pull-up whenever its latch holds 1.
// - A quasi pin turns on its weak pull-up only while latch and sensed level are both 1.
// - A quasi pin turns on its strong pull-down whenever its latch holds 0.
// - A quasi pin pulses its strong pull-up for exactly two clocks when its latch goes 0 to 1.
// - A quasi pin is input and output at once, its level readable while the latch holds 1.
// - An open-drain pin has no pull-up and pulls down only while its latch holds 0.
// - A push-pull pin drives low on latch 0 and strongly high on latch 1.
// - An input-only pin is never driven and is only sampled.
// - Every pin input passes glitch suppression before use.
// - The level register reads the pin levels and a write loads the latches of output pins.
// - Reset low restores every register to its default and resets the host interface.
module brbio_register_bank
(
   // Clock and reset
   input  wire        clk_sys,
   input  wire        resetn,
   // AXI4-Lite write address
   input  wire [31:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   // AXI4-Lite write data
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   // AXI4-Lite write response
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // AXI4-Lite read address
   input  wire [31:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   // AXI4-Lite read data
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // Pin pads: sensed level and drive enables
   input  wire [5:0]  pin_in,
   output reg  [5:0]  pin_pull_down_en,
   output reg  [5:0]  pin_very_weak_up_en,
   output reg  [5:0]  pin_weak_up_en,
   output reg  [5:0]  pin_strong_up_en,
   // Settings held for the bus engine
   output wire [7:0]  bus_clock_divider,
   output wire [7:0]  bus_timeout_setting,
   output wire        timeout_enable_bit,
   output wire [7:0]  own_bus_address
);

   parameter NUM_PROG = `BRBIO_NUM_PROG;
   parameter NUM_PINS = `BRBIO_NUM_PINS;

   // Type of one pin; fixed pins are always quasi
   function [1:0] pin_type;
      input [7:0] cfg;
      input integer idx;
      begin
         if (idx < NUM_PROG)
            pin_type = {cfg[2*idx+1], cfg[2*idx]};
         else
            pin_type = `BRBIO_TYPE_QUASI;
      end
   endfunction

   // Register index from a byte address, or an out-of-range marker
   function [3:0] reg_index;
      input [31:0] addr;
      begin
         if ((addr[31:5] == 27'h0) && (addr[4:2] <= `BRBIO_IDX_LAST))
            reg_index = {1'b0, addr[4:2]};
         else
            reg_index = 4'h8;
      end
   endfunction

   reg  [7:0]  pin_type_config_r;
   reg  [5:0]  pin_latch_r;
   reg  [7:0]  bus_clock_divider_r;
   reg  [7:0]  bus_timeout_setting_r;
   reg  [7:0]  own_bus_address_r;
   reg  [5:0]  latch_prev_r;
   reg  [5:0]  strong_pulse_r;
   reg  [5:0]  strong_pulse_nxt;
   reg  [1:0]  strong_cnt_r [0:5];
   reg  [31:0] awaddr_r;
   reg         aw_held_r;
   reg  [31:0] wdata_r;
   reg  [3:0]  wstrb_r;
   reg         w_held_r;
   wire [5:0]  pin_level;
   wire [7:0]  level_readback;
   wire [3:0]  wr_idx;
   wire [3:0]  rd_idx;
   wire        do_write;
   wire        byte0_en;
   integer     i;
   integer     j;
   integer     k;
   integer     m;

   // Filtered input path for every pin
   genvar g;
   generate
      for (g = 0; g < NUM_PINS; g = g + 1)
      begin : gen_filter
         brbio_glitch_filter u_filter
         (
            .clk_sys   (clk_sys),
            .resetn    (resetn),
            .pin_in    (pin_in[g]),
            .level_out (pin_level[g])
         );
      end
   endgenerate

   // Read shows real pin levels, upper bits zero
   assign level_readback = {2'h0, pin_level};

   assign bus_clock_divider   = bus_clock_divider_r;
   assign bus_timeout_setting = bus_timeout_setting_r;
   assign timeout_enable_bit  = bus_timeout_setting_r[0];
   assign own_bus_address     = own_bus_address_r;

   // Address and data are captured independently, in either order
   assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
   assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
   assign do_write      = aw_held_r && w_held_r && !s_axi_bvalid;
   assign wr_idx        = reg_index(awaddr_r);
   assign byte0_en      = wstrb_r[0];

   always @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         awaddr_r  <= 32'h0000_0000;
         aw_held_r <= 1'b0;
         wdata_r   <= 32'h0000_0000;
         wstrb_r   <= 4'h0;
         w_held_r  <= 1'b0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awaddr_r  <= s_axi_awaddr;
            aw_held_r <= 1'b1;
         end
         else if (do_write)
            aw_held_r <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
            w_held_r <= 1'b1;
         end
         else if (do_write)
            w_held_r <= 1'b0;
      end
   end

   // Register writes and write response; reset restores defaults
   always @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         pin_type_config_r     <= `BRBIO_RST_PIN_CONFIG;
         pin_latch_r           <= 6'h3f;
         bus_clock_divider_r   <= `BRBIO_RST_CLOCK_DIV;
         bus_timeout_setting_r <= `BRBIO_RST_TIMEOUT;
         own_bus_address_r     <= `BRBIO_RST_OWN_ADDR;
         s_axi_bvalid          <= 1'b0;
         s_axi_bresp           <= `BRBIO_RESP_OKAY;
      end
      else
      begin
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (do_write)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_idx[3] || (wr_idx[2:0] == `BRBIO_IDX_STATUS)) ?
                            `BRBIO_RESP_SLVERR : `BRBIO_RESP_OKAY;
            if (byte0_en && !wr_idx[3])
            begin
               case (wr_idx[2:0])
                  `BRBIO_IDX_PIN_CONFIG:
                     pin_type_config_r <= wdata_r[7:0];
                  `BRBIO_IDX_PIN_LEVEL:
                  begin
                     // Only output-capable pins take the new latch value
                     for (j = 0; j < NUM_PINS; j = j + 1)
                        if (pin_type(pin_type_config_r, j) != `BRBIO_TYPE_INPUT)
                           pin_latch_r[j] <= wdata_r[j];
                  end
                  `BRBIO_IDX_CLOCK_DIV:
                     bus_clock_divider_r <= wdata_r[7:0];
                  `BRBIO_IDX_TIMEOUT:
                     bus_timeout_setting_r <= wdata_r[7:0];
                  `BRBIO_IDX_OWN_ADDR:
                     own_bus_address_r <= wdata_r[7:0] & `BRBIO_ADDR_LSB_MASK;
                  default:
                     own_bus_address_r <= own_bus_address_r;
               endcase
            end
         end
      end
   end

   // Read channel: one access at a time, answer one cycle after address
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_idx        = reg_index(s_axi_araddr);

   always @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `BRBIO_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= rd_idx[3] ? `BRBIO_RESP_SLVERR : `BRBIO_RESP_OKAY;
         case (rd_idx)
            {1'b0, `BRBIO_IDX_PIN_CONFIG}: s_axi_rdata <= {24'h0, pin_type_config_r};
            {1'b0, `BRBIO_IDX_PIN_LEVEL}:  s_axi_rdata <= {24'h0, level_readback};
            {1'b0, `BRBIO_IDX_CLOCK_DIV}:  s_axi_rdata <= {24'h0, bus_clock_divider_r};
            {1'b0, `BRBIO_IDX_TIMEOUT}:    s_axi_rdata <= {24'h0, bus_timeout_setting_r};
            {1'b0, `BRBIO_IDX_STATUS}:     s_axi_rdata <= {24'h0, `BRBIO_RST_STATUS};
            {1'b0, `BRBIO_IDX_OWN_ADDR}:   s_axi_rdata <= {24'h0, own_bus_address_r};
            default:                       s_axi_rdata <= 32'h0000_0000;
         endcase
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // Strong pull-up pulse on a latch rise; counter gives its length
   always @*
   begin
      // Own loop index so no other process disturbs this one
      for (k = 0; k < NUM_PINS; k = k + 1)
         strong_pulse_nxt[k] = (!latch_prev_r[k] && pin_latch_r[k]) ||
                               (strong_pulse_r[k] &&
                                (strong_cnt_r[k] < (`BRBIO_STRONG_CYCLES - 1)) &&
                                pin_latch_r[k]);
   end

   always @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         latch_prev_r   <= 6'h3f;
         strong_pulse_r <= 6'h00;
         for (m = 0; m < NUM_PINS; m = m + 1)
            strong_cnt_r[m] <= 2'h0;
      end
      else
      begin
         latch_prev_r   <= pin_latch_r;
         strong_pulse_r <= strong_pulse_nxt;
         for (m = 0; m < NUM_PINS; m = m + 1)
            if (!latch_prev_r[m] && pin_latch_r[m])
               strong_cnt_r[m] <= 2'h0;
            else if (strong_pulse_r[m])
               strong_cnt_r[m] <= strong_cnt_r[m] + 2'h1;
      end
   end

   // Pad drive per pin type; registered so enables never glitch
   always @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         pin_pull_down_en    <= 6'h00;
         pin_very_weak_up_en <= 6'h00;
         pin_weak_up_en      <= 6'h00;
         pin_strong_up_en    <= 6'h00;
      end
      else
      begin
         for (i = 0; i < NUM_PINS; i = i + 1)
         begin
            case (pin_type(pin_type_config_r, i))
               `BRBIO_TYPE_QUASI:
               begin
                  pin_pull_down_en[i]    <= !pin_latch_r[i];
                  pin_very_weak_up_en[i] <= pin_latch_r[i];
                  pin_weak_up_en[i]      <= pin_latch_r[i] && pin_level[i];
                  pin_strong_up_en[i]    <= strong_pulse_nxt[i];
               end
               `BRBIO_TYPE_PUSH_PULL:
               begin
                  pin_pull_down_en[i]    <= !pin_latch_r[i];
                  pin_very_weak_up_en[i] <= 1'b0;
                  pin_weak_up_en[i]      <= 1'b0;
                  pin_strong_up_en[i]    <= pin_latch_r[i];
               end
               `BRBIO_TYPE_OPEN_DRAIN:
               begin
                  pin_pull_down_en[i]    <= !pin_latch_r[i];
                  pin_very_weak_up_en[i] <= 1'b0;
                  pin_weak_up_en[i]      <= 1'b0;
                  pin_strong_up_en[i]    <= 1'b0;
               end
               default:
               begin
                  // Input only: nothing drives the pad
                  pin_pull_down_en[i]    <= 1'b0;
                  pin_very_weak_up_en[i] <= 1'b0;
                  pin_weak_up_en[i]      <= 1'b0;
                  pin_strong_up_en[i]    <= 1'b0;
               end
            endcase
         end
      end
   end

   // Host link itself is outside this block; bus accesses stand for its frames

endmodule

// ===== design/brbio_defines.vh
// Purpose: Constants for the bridge register bank and I/O port
// Assumes: 32-bit AXI4-Lite word per register, 100 MHz system clock
// Notes:   Printed offsets are indices; byte address is four times the index
`ifndef BRBIO_DEFINES_VH
`define BRBIO_DEFINES_VH

// Register indices
`define BRBIO_IDX_PIN_CONFIG     3'h0
`define BRBIO_IDX_PIN_LEVEL      3'h1
`define BRBIO_IDX_CLOCK_DIV      3'h2
`define BRBIO_IDX_TIMEOUT        3'h3
`define BRBIO_IDX_STATUS         3'h4
`define BRBIO_IDX_OWN_ADDR       3'h5
`define BRBIO_IDX_LAST           3'h5

// Reset values
`define BRBIO_RST_PIN_CONFIG     8'h00
`define BRBIO_RST_PIN_LEVEL      8'h3f
`define BRBIO_RST_CLOCK_DIV      8'h19
`define BRBIO_RST_TIMEOUT        8'hfe
`define BRBIO_RST_STATUS         8'hf0
`define BRBIO_RST_OWN_ADDR       8'h00

// Pin type encodings
`define BRBIO_TYPE_QUASI         2'h0
`define BRBIO_TYPE_INPUT         2'h1
`define BRBIO_TYPE_PUSH_PULL     2'h2
`define BRBIO_TYPE_OPEN_DRAIN    2'h3

// Pin counts and field positions
`define BRBIO_NUM_PROG           4
`define BRBIO_NUM_PINS           6
`define BRBIO_LEVEL_MASK         8'h3f
`define BRBIO_ADDR_LSB_MASK      8'hfe

// Strong pull-up pulse length in system clock cycles
`define BRBIO_STRONG_CYCLES      2

// AXI responses
`define BRBIO_RESP_OKAY          2'h0
`define BRBIO_RESP_SLVERR        2'h2

`endif

// ===== design/brbio_glitch_filter.v
// Purpose: Synchronise one pin input and suppress short glitches
// Assumes: Pin level may change at any time relative to clk_sys
// Notes:   Output changes only after three equal synchronised samples

`include "brbio_defines.vh"

module brbio_glitch_filter
(
   // Clock and reset
   input  wire        clk_sys,
   input  wire        resetn,
   // Pin level in, filtered level out
   input  wire        pin_in,
   output reg         level_out
);

   reg         sync1_r;
   reg         sync2_r;
   reg  [1:0]  hist_r;

   // Two-flop synchroniser, then stability filter
   always @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         sync1_r   <= 1'b1;
         sync2_r   <= 1'b1;
         hist_r    <= 2'h3;
         level_out <= 1'b1;
      end
      else
      begin
         sync1_r <= pin_in;
         sync2_r <= sync1_r;
         hist_r  <= {hist_r[0], sync2_r};
         // Accept only a level held for three samples
         if ((hist_r == 2'h3) && sync2_r)
            level_out <= 1'b1;
         else if ((hist_r == 2'h0) && !sync2_r)
            level_out <= 1'b0;
      end
   end

endmodule

// ===== tb/brbio_chk_sva.sv
// Purpose: Port checker for the register bank and I/O port
// Assumes: Pins 4 and 5 are always quasi, so pad timing is watched on pin 4
// Notes:   Bound into every bank instance
module brbio_chk
(
   // Clock and reset
   input wire        clk_sys,
   input wire        resetn,
   // Bus handshakes
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   // Pads
   input wire [5:0]  pin_in,
   input wire [5:0]  pin_pull_down_en,
   input wire [5:0]  pin_very_weak_up_en,
   input wire [5:0]  pin_weak_up_en,
   input wire [5:0]  pin_strong_up_en
);
   timeunit 1ns;
   timeprecision 1ps;
   // Short names for the pad enables
   wire [5:0]  pd = pin_pull_down_en;
   wire [5:0]  vw = pin_very_weak_up_en;
   wire [5:0]  wk = pin_weak_up_en;
   wire [5:0]  st = pin_strong_up_en;
   logic [3:0] lo_r;
   logic [3:0] hi_r;
   // Run lengths of pin 4 pad level; saturate so they never wrap
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         lo_r <= 4'h0;
         hi_r <= 4'h0;
      end
      else
      begin
         lo_r <= pin_in[4] ? 4'h0 : lo_r + {3'h0, lo_r != 4'hf};
         hi_r <= pin_in[4] ? hi_r + {3'h0, hi_r != 4'hf} : 4'h0;
      end
   end
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);
   // Latch rising seen as pull-down giving way to the very weak pull-up
   sequence s_latch_up;
      $rose(vw[4]) && $past(pd[4]);
   endsequence
   sequence s_pulse2;
      st[4] ##1 st[4] ##1 !st[4];
   endsequence
   sequence s_wboth;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   property p_no_fight;
      (pd & (vw | wk | st)) == 6'h00;
   endproperty
   a_no_fight: assert property (p_no_fight)
      else $error("pull-down with pull-up");
   property p_weak_latch;
      (wk & ~vw) == 6'h00;
   endproperty
   a_weak_latch: assert property (p_weak_latch)
      else $error("weak without latch");
   property p_fixed_quasi;
      $past(resetn) |-> (pd[5:4] ^ vw[5:4]) == 2'h3;
   endproperty
   a_fixed_quasi: assert property (p_fixed_quasi)
      else $error("fixed pin not quasi");
   property p_strong_pulse;
      s_latch_up |-> s_pulse2;
   endproperty
   a_strong_pulse: assert property (p_strong_pulse)
      else $error("strong pulse length");
   property p_weak_drop;
      lo_r > 4'h7 |-> !wk[4];
   endproperty
   a_weak_drop: assert property (p_weak_drop)
      else $error("weak kept on low pad");
   property p_weak_hold;
      hi_r > 4'h7 && vw[4] |-> wk[4];
   endproperty
   a_weak_hold: assert property (p_weak_hold)
      else $error("weak off on high pad");
   property p_b_stand;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
   endproperty
   a_b_stand: assert property (p_b_stand)
      else $error("bvalid dropped");
   property p_r_stand;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_stand: assert property (p_r_stand)
      else $error("read data dropped");
   property p_w_answer;
      s_wboth |-> ##[1:2] s_axi_bvalid;
   endproperty
   a_w_answer: assert property (p_w_answer)
      else $error("no write answer");
endmodule

bind brbio_register_bank brbio_chk u_chk
(
   .clk_sys, .resetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
   .s_axi_rready, .pin_in, .pin_pull_down_en, .pin_very_weak_up_en, .pin_weak_up_en,
   .pin_strong_up_en
);

// ===== tb/brbio_pad_model.sv
// Purpose: Pads and board around the I/O port
// Assumes: Every pin has an outside pull-up resistor
// Notes:   An outside sink beats the weak pull-ups, never a strong drive
module brbio_pad_model
(
   // Drive from the port and from outside
   input  wire [5:0] pd_en,
   input  wire [5:0] st_en,
   input  wire [5:0] ext_low,
   // Resolved pad level
   output wire [5:0] pin_lvl
);
   timeunit 1ns;
   timeprecision 1ps;
   // Undriven pads float up on the resistor
   assign pin_lvl = ~pd_en & (st_en | ~ext_low);
endmodule

// ===== tb/bridge_register_bank_io_port_tb_top.sv
// Purpose: Self-checking bench for the register bank and I/O port
// Assumes: Handshakes are judged on values settled before each edge
// Notes:   Model holds registers, latches and pad levels
module bridge_register_bank_io_port_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys = 1'b0;
   logic        resetn = 1'b0;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [5:0]  ext_low = 6'h00;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire  [1:0]  s_axi_bresp, s_axi_rresp;
   wire  [31:0] s_axi_rdata;
   wire  [5:0]  pin_in, pin_pull_down_en, pin_very_weak_up_en, pin_weak_up_en;
   wire  [5:0]  pin_strong_up_en;
   wire  [7:0]  bus_clock_divider, bus_timeout_setting, own_bus_address;
   wire         timeout_enable_bit;
   logic [7:0]  mdl [6];
   logic [5:0]  lat;
   logic [31:0] rd, rs;
   logic        l0;
   int          seed = 2, err_total = 0, num_checks = 0;
   logic [31:0] c;

   brbio_register_bank DUT
   (
      .clk_sys, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_pull_down_en, .pin_very_weak_up_en,
      .pin_weak_up_en, .pin_strong_up_en, .bus_clock_divider, .bus_timeout_setting,
      .timeout_enable_bit, .own_bus_address
   );
   brbio_pad_model u_pad
   (
      .pd_en(pin_pull_down_en), .st_en(pin_strong_up_en), .ext_low, .pin_lvl(pin_in)
   );
   // 100 MHz system clock
   always #5 clk_sys = ~clk_sys;

   task automatic end_sim();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Count every comparison, report a mismatch at once
   task automatic cmp_bus(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e)
      begin
         err_total++;
         $display("wrong value at %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic cmp_pin(input logic [3:0] g, input logic [3:0] e);
      cmp_bus({28'h0, g}, {28'h0, e});
   endtask
   function automatic void mrst();
      mdl = '{8'h00, 8'h3f, 8'h19, 8'hfe, 8'hf0, 8'h00};
      lat = 6'h3f;
   endfunction
   function automatic logic [1:0] typ(int n);
      return (n < 4) ? mdl[0][2*n+:2] : 2'h0;
   endfunction
   // Pad level: pull-down loses only where input-only or latch 1
   function automatic logic lvl(int n);
      return (typ(n) == 2'h1 || lat[n]) && ((typ(n) == 2'h2 && lat[n]) || !ext_low[n]);
   endfunction
   // Steady enables as {pull-down, very weak, weak, strong}
   function automatic logic [3:0] en(int n);
      case (typ(n))
         2'h0: return {~lat[n], lat[n], lat[n] & lvl(n), 1'b0};
         2'h1: return 4'h0;
         2'h2: return {~lat[n], 2'h0, lat[n]};
         default: return {~lat[n], 3'h0};
      endcase
   endfunction
   function automatic logic [3:0] got(int n);
      return {pin_pull_down_en[n], pin_very_weak_up_en[n], pin_weak_up_en[n],
              pin_strong_up_en[n]};
   endfunction
   // Model write; latches of input-only pins ignore the level write
   function automatic logic [1:0] mwr(int i, logic [7:0] d);
      if (i == 4 || i > 5)
         return 2'h2;
      if (!s_axi_wstrb[0])
         return 2'h0;
      if (i != 1)
         mdl[i] = (i == 5) ? (d & 8'hfe) : d;
      for (int n = 0; n < 6; n++)
         if (i == 1 && typ(n) != 2'h1)
            lat[n] = d[n];
      return 2'h0;
   endfunction
   function automatic logic [31:0] mrd(int i);
      logic [31:0] v;
      v = 32'h0;
      for (int n = 0; n < 6; n++)
         v[n] = lvl(n);
      return (i == 1) ? v : (i > 5) ? 32'h0 : {24'h00_0000, mdl[i]};
   endfunction
   // Write: address and data offered together, each released when taken
   task automatic wr(input int i, input logic [7:0] d);
      logic ha, hw, hb;
      @(posedge clk_sys);
      s_axi_awaddr <= 32'(i * 4);
      s_axi_wdata <= {24'h00_0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      hb = 1'b0;
      // Only the watchdog ends a wait
      while (!hb)
      begin
         @(negedge clk_sys);
         ha = s_axi_awvalid & s_axi_awready;
         hw = s_axi_wvalid & s_axi_wready;
         hb = s_axi_bvalid & s_axi_bready;
         rs = {30'h0, s_axi_bresp};
         @(posedge clk_sys);
         if (ha) s_axi_awvalid <= 1'b0;
         if (hw) s_axi_wvalid <= 1'b0;
         if (hb) s_axi_bready <= 1'b0;
      end
      cmp_bus(rs, {30'h0, mwr(i, d)});
   endtask
   task automatic rdc(input int i);
      logic ha, hr, hv;
      @(posedge clk_sys);
      s_axi_araddr <= 32'(i * 4);
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'($random(seed)); // Late ready makes read data stand
      hr = 1'b0;
      while (!hr)
      begin
         @(negedge clk_sys);
         ha = s_axi_arvalid & s_axi_arready;
         hv = s_axi_rvalid;
         hr = hv & s_axi_rready;
         rd = s_axi_rdata;
         rs = {30'h0, s_axi_rresp};
         @(posedge clk_sys);
         if (ha) s_axi_arvalid <= 1'b0;
         if (hr) s_axi_rready <= 1'b0;
         else if (hv) s_axi_rready <= 1'b1;
      end
      cmp_bus(rs, (i > 5) ? 32'h2 : 32'h0);
      cmp_bus(rd, mrd(i));
   endtask
   task automatic chk_pins();
      for (int n = 0; n < 6; n++)
         cmp_pin(got(n), en(n));
   endtask
   task automatic chk_regs();
      for (int i = 0; i < 8; i++)
         rdc(i);
      cmp_bus({bus_clock_divider, bus_timeout_setting, own_bus_address, 7'h0,
               timeout_enable_bit}, {mdl[2], mdl[3], mdl[5], 7'h0, mdl[3][0]});
   endtask
   // A hang ends the run at 30000 cycles, well beyond the roughly one thousand cycles needed
   initial
   begin
      #300000;
      err_total++;
      end_sim();
   end
   initial
   begin
      mrst();
      repeat (2) @(posedge clk_sys);
      resetn <= 1'b1;
      // Defaults, then random values into indices 2 to 7 including refused places
      chk_regs();
      for (int i = 2; i < 8; i++)
      begin
         // Random strobes: a clear byte 0 lane must leave the register alone
         s_axi_wstrb <= 4'($random(seed));
         wr(i, 8'($random(seed)));
      end
      s_axi_wstrb <= 4'hf;
      chk_regs();
      // Every type on every programmable pin; latch data flips per pass
      for (int n = 0; n < 4; n++)
         for (int t = 0; t < 4; t++)
         begin
            wr(0, 8'(t << (2 * n)));
            repeat (8) @(negedge clk_sys);
            chk_pins();
            for (int p = 0; p < 2; p++)
            begin
               l0 = lat[n];
               wr(1, ((n + t + p) % 2) ? 8'h3f : 8'h00);
               c = 0;
               repeat (10)
               begin
                  @(negedge clk_sys);
                  c += pin_strong_up_en[n];
               end
               cmp_bus(32'(c), (t == 0 && !l0 && lat[n]) ? 2 : (t == 2 && lat[n]) ? 10 : 0);
               chk_pins();
               rdc(1);
            end
         end
      // Outside sink against the weak pull-ups
      wr(0, 8'h00);
      wr(1, 8'h3f);
      repeat (6)
      begin
         @(posedge clk_sys);
         ext_low <= 6'($random(seed));
         repeat (12) @(negedge clk_sys);
         chk_pins();
         rdc(1);
      end
      // One-cycle spike must not reach the weak pull-up
      @(posedge clk_sys);
      ext_low <= 6'h00;
      repeat (10) @(posedge clk_sys);
      ext_low <= 6'h20;
      @(posedge clk_sys);
      ext_low <= 6'h00;
      c = 0;
      repeat (10)
      begin
         @(negedge clk_sys);
         c += !pin_weak_up_en[5];
      end
      cmp_bus(32'(c), 32'h0);
      // Reset in mid-run restores every default
      wr(0, 8'h9c);
      @(posedge clk_sys);
      resetn <= 1'b0;
      mrst();
      repeat (2) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (8) @(negedge clk_sys);
      chk_pins();
      chk_regs();
      end_sim();
   end
endmodule
